/* test/slr_remote_node.sv */
`default_nettype none
module slr_remote_node (
    input  wire logic clk,
    input  wire logic sample_tick,
    input  wire logic invert,
    output logic      rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic level;

    // idle is mark; between characters the model drives the line back to mark
    assign rx_pin = level ^ invert;

    initial level = 1'b1;

    // one bit lasts sixteen ticks; the level only moves after a falling edge
    task automatic hold_bit(input logic v);
        int n;
        n = 0;
        @(negedge clk);
        level = v;
        while (n < 16)
        begin
            @(posedge clk);
            if (sample_tick === 1'b1)
                n++;
        end
    endtask

    // start, data lsb first, then a stop bit that may be forced low
    task automatic send_char(input logic [8:0] d, input int nb, input logic stop);
        hold_bit(1'b0);
        for (int i = 0; i < nb; i++)
            hold_bit(d[i]);
        hold_bit(stop);
        @(negedge clk);
        level = 1'b1;
    endtask

    task automatic send_low(input int nb);
        for (int i = 0; i < nb; i++)
            hold_bit(1'b0);
        @(negedge clk);
        level = 1'b1;
    endtask
endmodule
`default_nettype wire

/* test/test_slr_rx_status_lin.sv */
`default_nettype none
module test_slr_rx_status_lin;
    timeunit 1ns;
    timeprecision 1ps;
    import slr_pkg::*;

    localparam logic [15:0] A_S1 = BASE_BLOCKING + OFF_STATUS_ONE;
    localparam logic [15:0] A_S2 = BASE_BLOCKING + OFF_STATUS_TWO;
    localparam logic [15:0] A_DAT = BASE_NONBLOCKING + OFF_DATA;

    logic        clk = 1'b0;
    logic        sample_tick = 1'b0;
    logic        reset, rx_pin, nine_bit_mode, parity_check_on;
    logic        parity_odd, rx_standby, tx_break_req, reg_rd, reg_wr, invert;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic        framing_error_flag, parity_error_flag, rx_full_flag, idle_flag;
    logic        break_seen_flag, rx_edge_flag, tx_break_line;
    logic [5:0]  flags;
    int          error_cnt, compares;

    assign flags = {break_seen_flag, rx_edge_flag, idle_flag, rx_full_flag,
                    parity_error_flag, framing_error_flag};

    slr_rx_status_lin u_slr_rx_status_lin (
        .clk(clk), .reset(reset), .sample_tick(sample_tick), .rx_pin(rx_pin),
        .nine_bit_mode(nine_bit_mode), .parity_check_on(parity_check_on),
        .parity_odd(parity_odd), .rx_standby(rx_standby), .tx_break_req(tx_break_req),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .framing_error_flag(framing_error_flag),
        .parity_error_flag(parity_error_flag), .rx_full_flag(rx_full_flag),
        .idle_flag(idle_flag), .break_seen_flag(break_seen_flag),
        .rx_edge_flag(rx_edge_flag), .tx_break_line(tx_break_line)
    );

    slr_remote_node u_slr_remote_node (
        .clk(clk), .sample_tick(sample_tick), .invert(invert), .rx_pin(rx_pin)
    );

    always #2 clk = ~clk;

    // tick every other cycle keeps a bit at 32 clocks and the run short
    always @(negedge clk) sample_tick <= ~sample_tick;

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_read(input logic [15:0] a, output logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        v = reg_rdata;
    endtask

    task automatic reg_write(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic clear_seq(output logic [7:0] v);
        logic [7:0] s;
        reg_read(A_S1, s);
        reg_read(A_DAT, v);
    endtask

    task automatic wait_flag(input int b);
        int n;
        n = 0;
        while (flags[b] !== 1'b1 && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 4000)
        begin
            error_cnt++;
            $display("unexpected wait: flag %0d never rose", b);
            complete_run();
        end
    endtask

    task automatic test_regs();
        reg_read(A_S2, d);
        check("status two reset", d, 8'h00);
        reg_write(A_S2, 8'h2E);
        reg_read(BASE_NONBLOCKING + OFF_STATUS_TWO, d);
        check("status two stored", d, 8'h0E);
        reg_write(BASE_NONBLOCKING + OFF_STATUS_TWO, 8'h00);
        reg_read(BASE_BLOCKING + 16'h0046, d);
        check("unmapped read", d, 8'h00);
        $display("test regs done");
    endtask

    task automatic test_good_char();
        u_slr_remote_node.send_char(9'h0A5, 8, 1'b1);
        wait_flag(2);
        check("fe on good char", 8'(framing_error_flag), 8'h00);
        check("edge flag", 8'(rx_edge_flag), 8'h01);
        reg_write(A_S2, 8'h00);
        check("edge kept", 8'(rx_edge_flag), 8'h01);
        reg_write(A_S2, 8'h40);
        check("edge cleared", 8'(rx_edge_flag), 8'h00);
        clear_seq(d);
        check("data", d, 8'hA5);
        check("full cleared", 8'(rx_full_flag), 8'h00);
        $display("test good char done");
    endtask

    task automatic test_framing();
        reg_write(A_S2, 8'h04);
        u_slr_remote_node.send_char(9'h03C, 8, 1'b0);
        wait_flag(2);
        check("fe with full", 8'(framing_error_flag), 8'h01);
        reg_read(A_DAT, d);
        check("fe after data only", 8'(framing_error_flag), 8'h01);
        clear_seq(d);
        check("fe cleared", 8'(framing_error_flag), 8'h00);
        reg_write(A_S2, 8'h00);
        $display("test framing done");
    endtask

    task automatic test_parity();
        logic [8:0] pd [4];
        logic [3:0] pnine, podd, perr;
        pd = '{9'h001, 9'h001, 9'h101, 9'h101};
        pnine = 4'b1100;
        podd = 4'b0110;
        perr = 4'b0101;
        parity_check_on = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            nine_bit_mode = pnine[i];
            parity_odd = podd[i];
            u_slr_remote_node.send_char(pd[i], pnine[i] ? 9 : 8, 1'b1);
            wait_flag(2);
            check("parity flag", 8'(parity_error_flag), 8'(perr[i]));
            clear_seq(d);
            check("parity cleared", 8'(parity_error_flag), 8'h00);
        end
        parity_check_on = 1'b0;
        nine_bit_mode = 1'b0;
        $display("test parity done");
    endtask

    task automatic test_break();
        reg_write(A_S2, 8'h02);
        u_slr_remote_node.send_low(10);
        repeat (96) @(negedge clk);
        check("no break at 10", 8'(break_seen_flag), 8'h00);
        check("full held off", {6'h00, rx_full_flag, framing_error_flag}, 8'h00);
        u_slr_remote_node.send_low(12);
        wait_flag(5);
        // the low tail restarts the receiver; let that frame end while detection is on
        repeat (384) @(negedge clk);
        check("full after break", 8'(rx_full_flag), 8'h00);
        reg_read(A_S2, d);
        check("status two flag", {6'h00, d[7], d[5]}, 8'h02);
        reg_write(A_S2, 8'h02);
        check("break kept", 8'(break_seen_flag), 8'h01);
        reg_write(A_S2, 8'hC2);
        check("break cleared", 8'(break_seen_flag), 8'h00);
        reg_write(A_S2, 8'h00);
        $display("test break done");
    endtask

    task automatic test_invert();
        reg_write(A_S2, 8'h10);
        invert = 1'b1;
        repeat (96) @(negedge clk);
        reg_write(A_S2, 8'hD0);
        clear_seq(d);
        u_slr_remote_node.send_char(9'h05A, 8, 1'b1);
        wait_flag(2);
        check("rising edge flag", 8'(rx_edge_flag), 8'h01);
        check("fe inverted", 8'(framing_error_flag), 8'h00);
        clear_seq(d);
        check("inverted data", d, 8'h5A);
        reg_write(A_S2, 8'h00);
        invert = 1'b0;
        repeat (96) @(negedge clk);
        reg_write(A_S2, 8'hC0);
        clear_seq(d);
        $display("test invert done");
    endtask

    task automatic test_idle();
        rx_standby = 1'b1;
        u_slr_remote_node.send_char(9'h055, 8, 1'b1);
        repeat (448) @(negedge clk);
        check("idle held in standby", 8'(idle_flag), 8'h00);
        reg_write(A_S2, 8'h08);
        u_slr_remote_node.send_char(9'h055, 8, 1'b1);
        wait_flag(3);
        clear_seq(d);
        check("idle cleared", 8'(idle_flag), 8'h00);
        rx_standby = 1'b0;
        reg_write(A_S2, 8'h40);
        $display("test idle done");
    endtask

    task automatic test_tx_break();
        int n, k;
        for (int i = 0; i < 4; i++)
        begin
            reg_write(A_S2, i[1] ? 8'h04 : 8'h00);
            nine_bit_mode = i[0];
            @(negedge clk);
            tx_break_req = 1'b1;
            @(negedge clk);
            tx_break_req = 1'b0;
            n = 0;
            k = 0;
            while (tx_break_line === 1'b1 && k < 2000)
            begin
                @(posedge clk);
                if (sample_tick === 1'b1)
                    n++;
                @(negedge clk);
                k++;
            end
            if (k >= 2000)
            begin
                error_cnt++;
                $display("unexpected break wait: line never fell");
                complete_run();
            end
            check("break ticks", 8'(n / 16), 8'((i[1] ? 13 : 10) + i[0]));
            check("break tick rest", 8'(n % 16), 8'h00);
        end
        nine_bit_mode = 1'b0;
        reg_write(A_S2, 8'h00);
        $display("test tx break done");
    endtask

    initial
    begin
        reset = 1'b1;
        nine_bit_mode = 1'b0;
        parity_check_on = 1'b0;
        parity_odd = 1'b0;
        rx_standby = 1'b0;
        tx_break_req = 1'b0;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        invert = 1'b0;
        error_cnt = 0;
        compares = 0;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        test_regs();
        test_good_char();
        test_framing();
        test_parity();
        test_break();
        test_invert();
        test_idle();
        test_tx_break();
        complete_run();
    end
endmodule
`default_nettype wire

/* verilog/slr_pkg.sv */
`default_nettype none
package slr_pkg;
    localparam logic [15:0] BASE_BLOCKING    = 16'h0200;
    localparam logic [15:0] BASE_NONBLOCKING = 16'h0300;
    localparam logic [15:0] OFF_STATUS_ONE   = 16'h0044;
    localparam logic [15:0] OFF_STATUS_TWO   = 16'h0045;
    localparam logic [15:0] OFF_DATA         = 16'h0047;

    localparam int S1_FULL  = 5;
    localparam int S1_IDLE  = 4;
    localparam int S1_FE    = 1;
    localparam int S1_PF    = 0;
    localparam int S2_BRK   = 7;
    localparam int S2_EDGE  = 6;
    localparam int S2_INV   = 4;
    localparam int S2_STANDBY_IDLE_WAKE_SEL = 3;
    localparam int S2_LONG_BREAK_SEL = 2;
    localparam int S2_BREAK_DETECT_ENABLE = 1;
    localparam int S2_RAF   = 0;

    localparam logic       RESET_CTRL      = 1'h0;
    localparam logic [3:0] MID_TICK        = 4'h7;
    localparam logic [3:0] LAST_TICK       = 4'hF;
    localparam logic [3:0] RX_BRK_SHORT    = 4'hA;
    localparam logic [3:0] RX_BRK_LONG     = 4'hB;
    localparam logic [3:0] IDLE_BITS_8     = 4'hA;
    localparam logic [3:0] IDLE_BITS_9     = 4'hB;
    localparam logic [4:0] TX_BRK_SHORT    = 5'h0A;
    localparam logic [4:0] TX_BRK_LONG     = 5'h0D;
    localparam logic [3:0] LAST_BIT_8      = 4'h7;
    localparam logic [3:0] LAST_BIT_9      = 4'h8;

    typedef enum logic [3:0] {
        SLR_RX_IDLE  = 4'h1,
        SLR_RX_START = 4'h2,
        SLR_RX_DATA  = 4'h4,
        SLR_RX_STOP  = 4'h8
    } slr_rx_state_t;

    function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] off);
        addr_hit = (addr == BASE_BLOCKING + off) || (addr == BASE_NONBLOCKING + off);
    endfunction

    function automatic logic [4:0] tx_break_len(input logic long_sel, input logic nine);
        tx_break_len = (long_sel ? TX_BRK_LONG : TX_BRK_SHORT) + {4'h0, nine};
    endfunction
endpackage
`default_nettype wire

/* verilog/slr_rx_frame.sv */
`default_nettype none
module slr_rx_frame (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       sample_tick,
    input  wire logic       rx_line,
    input  wire logic       nine_bit_mode,
    input  wire logic       long_break,
    output logic            char_done,
    output logic            stop_bad,
    output logic [8:0]      char_bits,
    output logic            break_pulse,
    output logic            idle_pulse,
    output logic            rx_busy
);
    import slr_pkg::*;

    typedef struct packed {
        slr_rx_state_t state;
        logic [3:0]    tick;
        logic [3:0]    bit_idx;
        logic [8:0]    bits;
        logic          done;
        logic          stop_bad;
        logic [3:0]    low_ticks;
        logic [3:0]    low_bits;
        logic          brk;
        logic          active;
        logic [3:0]    high_ticks;
        logic [3:0]    high_bits;
        logic          idle;
    } slr_frame_t;

    slr_frame_t st;
    slr_frame_t next_st;
    logic [3:0] brk_thresh;
    logic [3:0] idle_len;

    assign brk_thresh = long_break ? RX_BRK_LONG : RX_BRK_SHORT;
    assign idle_len   = nine_bit_mode ? IDLE_BITS_9 : IDLE_BITS_8;

    always_comb
    begin
        next_st       = st;
        next_st.done  = 1'b0;
        next_st.brk   = 1'b0;
        next_st.idle  = 1'b0;
        if (sample_tick)
        begin
            case (st.state)
                SLR_RX_IDLE:
                begin
                    next_st.tick = 4'h0;
                    if (!rx_line)
                        next_st.state = SLR_RX_START;
                end
                SLR_RX_START:
                begin
                    next_st.tick = st.tick + 4'h1;
                    if (st.tick == MID_TICK)
                    begin
                        next_st.tick    = 4'h0;
                        next_st.bit_idx = 4'h0;
                        next_st.state   = rx_line ? SLR_RX_IDLE : SLR_RX_DATA;
                    end
                end
                SLR_RX_DATA:
                begin
                    next_st.tick = st.tick + 4'h1;
                    if (st.tick == LAST_TICK)
                    begin
                        next_st.bits[st.bit_idx] = rx_line;
                        next_st.bit_idx          = st.bit_idx + 4'h1;
                        if (st.bit_idx == (nine_bit_mode ? LAST_BIT_9 : LAST_BIT_8))
                            next_st.state = SLR_RX_STOP;
                    end
                end
                SLR_RX_STOP:
                begin
                    next_st.tick = st.tick + 4'h1;
                    if (st.tick == LAST_TICK)
                    begin
                        next_st.done     = 1'b1;
                        next_st.stop_bad = !rx_line;
                        if (!nine_bit_mode)
                            next_st.bits[8] = 1'b0;
                        next_st.state = SLR_RX_IDLE;
                    end
                end
                default: next_st.state = SLR_RX_IDLE;
            endcase
            // low run length, counted apart from framing so a break spans frames
            if (!rx_line)
            begin
                next_st.active     = 1'b1;
                next_st.high_ticks = 4'h0;
                next_st.high_bits  = 4'h0;
                next_st.low_ticks  = st.low_ticks + 4'h1;
                if (st.low_ticks == LAST_TICK && st.low_bits != LAST_TICK)
                begin
                    next_st.low_bits = st.low_bits + 4'h1;
                    next_st.brk      = (st.low_bits + 4'h1) == brk_thresh;
                end
            end
            else
            begin
                next_st.low_ticks  = 4'h0;
                next_st.low_bits   = 4'h0;
                next_st.high_ticks = st.high_ticks + 4'h1;
                if (st.high_ticks == LAST_TICK && st.active)
                begin
                    next_st.high_bits = st.high_bits + 4'h1;
                    if ((st.high_bits + 4'h1) == idle_len)
                    begin
                        next_st.idle   = 1'b1;
                        next_st.active = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st       <= '0;
            st.state <= SLR_RX_IDLE;
        end
        else
            st <= next_st;
    end

    assign char_done   = st.done;
    assign stop_bad    = st.stop_bad;
    assign char_bits   = st.bits;
    assign break_pulse = st.brk;
    assign idle_pulse  = st.idle;
    assign rx_busy     = st.state != SLR_RX_IDLE;
endmodule
`default_nettype wire

/* verilog/slr_rx_status_lin.sv */
`default_nettype none
module slr_rx_status_lin (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        sample_tick,
    input  wire logic        rx_pin,
    input  wire logic        nine_bit_mode,
    input  wire logic        parity_check_on,
    input  wire logic        parity_odd,
    input  wire logic        rx_standby,
    input  wire logic        tx_break_req,
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    output logic             framing_error_flag,
    output logic             parity_error_flag,
    output logic             rx_full_flag,
    output logic             idle_flag,
    output logic             break_seen_flag,
    output logic             rx_edge_flag,
    output logic             tx_break_line
);
    import slr_pkg::*;

    typedef struct packed {
        logic       framing_error_flag;
        logic       parity_error_flag;
        logic       rx_full_flag;
        logic       idle_flag;
        logic       break_seen_flag;
        logic       rx_edge_flag;
        logic       rx_polarity_flip;
        logic       standby_idle_wake_sel;
        logic       long_break_sel;
        logic       break_detect_enable;
        logic       arm_fe;
        logic       arm_pf;
        logic       arm_full;
        logic       arm_idle;
        logic [8:0] data;
        logic [7:0] rdata;
        logic       line_prev;
        logic       tx_brk;
        logic [3:0] tx_tick;
        logic [4:0] tx_bits;
    } slr_state_t;

    slr_state_t st;
    slr_state_t next_st;
    logic       line;
    logic       char_done;
    logic       stop_bad;
    logic [8:0] char_bits;
    logic       break_pulse;
    logic       idle_pulse;
    logic       rx_busy;
    logic       rd_s1;
    logic       rd_s2;
    logic       rd_dat;
    logic       wr_s2;
    logic [4:0] brk_len;

    function automatic logic parity_bad(input logic [8:0] b, input logic nine, input logic odd);
        parity_bad = (^b[7:0]) ^ (nine & b[8]) ^ odd;
    endfunction

    assign line    = rx_pin ^ st.rx_polarity_flip;
    assign rd_s1   = reg_rd && addr_hit(reg_addr, OFF_STATUS_ONE);
    assign rd_s2   = reg_rd && addr_hit(reg_addr, OFF_STATUS_TWO);
    assign rd_dat  = reg_rd && addr_hit(reg_addr, OFF_DATA);
    assign wr_s2   = reg_wr && addr_hit(reg_addr, OFF_STATUS_TWO);
    assign brk_len = tx_break_len(st.long_break_sel, nine_bit_mode);

    slr_rx_frame u_frame (
        .clk           (clk),
        .reset         (reset),
        .sample_tick   (sample_tick),
        .rx_line       (line),
        .nine_bit_mode (nine_bit_mode),
        .long_break    (st.break_detect_enable),
        .char_done     (char_done),
        .stop_bad      (stop_bad),
        .char_bits     (char_bits),
        .break_pulse   (break_pulse),
        .idle_pulse    (idle_pulse),
        .rx_busy       (rx_busy)
    );

    always_comb
    begin
        next_st           = st;
        next_st.line_prev = line;
        // reads: first step of the clear sequences arms what is set now
        if (rd_s1)
        begin
            next_st.arm_fe   = st.framing_error_flag;
            next_st.arm_pf   = st.parity_error_flag;
            next_st.arm_full = st.rx_full_flag;
            next_st.arm_idle = st.idle_flag;
            next_st.rdata    = 8'h00;
            next_st.rdata[S1_FULL] = st.rx_full_flag;
            next_st.rdata[S1_IDLE] = st.idle_flag;
            next_st.rdata[S1_FE]   = st.framing_error_flag;
            next_st.rdata[S1_PF]   = st.parity_error_flag;
        end
        else if (rd_s2)
        begin
            next_st.rdata           = 8'h00;
            next_st.rdata[S2_BRK]   = st.break_seen_flag;
            next_st.rdata[S2_EDGE]  = st.rx_edge_flag;
            next_st.rdata[S2_INV]   = st.rx_polarity_flip;
            next_st.rdata[S2_STANDBY_IDLE_WAKE_SEL] = st.standby_idle_wake_sel;
            next_st.rdata[S2_LONG_BREAK_SEL] = st.long_break_sel;
            next_st.rdata[S2_BREAK_DETECT_ENABLE] = st.break_detect_enable;
            next_st.rdata[S2_RAF]   = rx_busy;
        end
        else if (rd_dat)
        begin
            next_st.rdata = st.data[7:0];
            if (st.arm_fe)
                next_st.framing_error_flag = 1'b0;
            if (st.arm_pf)
                next_st.parity_error_flag = 1'b0;
            if (st.arm_full)
                next_st.rx_full_flag = 1'b0;
            if (st.arm_idle)
                next_st.idle_flag = 1'b0;
            next_st.arm_fe   = 1'b0;
            next_st.arm_pf   = 1'b0;
            next_st.arm_full = 1'b0;
            next_st.arm_idle = 1'b0;
        end
        else if (reg_rd)
            next_st.rdata = 8'h00;
        if (wr_s2)
        begin
            if (reg_wdata[S2_BRK])
                next_st.break_seen_flag = 1'b0;
            if (reg_wdata[S2_EDGE])
                next_st.rx_edge_flag = 1'b0;
            next_st.rx_polarity_flip      = reg_wdata[S2_INV];
            next_st.standby_idle_wake_sel = reg_wdata[S2_STANDBY_IDLE_WAKE_SEL];
            next_st.long_break_sel        = reg_wdata[S2_LONG_BREAK_SEL];
            next_st.break_detect_enable   = reg_wdata[S2_BREAK_DETECT_ENABLE];
        end
        // hardware sets come last so a set in the clearing cycle wins
        if (st.line_prev && !line)
            next_st.rx_edge_flag = 1'b1;
        if (char_done && !st.break_detect_enable)
        begin
            next_st.rx_full_flag = 1'b1;
            next_st.data         = char_bits;
            if (stop_bad)
                next_st.framing_error_flag = 1'b1;
            if (parity_check_on && parity_bad(char_bits, nine_bit_mode, parity_odd))
                next_st.parity_error_flag = 1'b1;
        end
        if (break_pulse && st.break_detect_enable)
            next_st.break_seen_flag = 1'b1;
        if (idle_pulse && (!rx_standby || st.standby_idle_wake_sel))
            next_st.idle_flag = 1'b1;
        // transmitted break, timed in oversample ticks
        if (tx_break_req && !st.tx_brk)
        begin
            next_st.tx_brk  = 1'b1;
            next_st.tx_tick = 4'h0;
            next_st.tx_bits = 5'h00;
        end
        else if (st.tx_brk && sample_tick)
        begin
            next_st.tx_tick = st.tx_tick + 4'h1;
            if (st.tx_tick == LAST_TICK)
            begin
                next_st.tx_bits = st.tx_bits + 5'h01;
                if ((st.tx_bits + 5'h01) == brk_len)
                    next_st.tx_brk = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st           <= '0;
            st.line_prev <= ~RESET_CTRL;
        end
        else
            st <= next_st;
    end

    assign reg_rdata          = st.rdata;
    assign framing_error_flag = st.framing_error_flag;
    assign parity_error_flag  = st.parity_error_flag;
    assign rx_full_flag       = st.rx_full_flag;
    assign idle_flag          = st.idle_flag;
    assign break_seen_flag    = st.break_seen_flag;
    assign rx_edge_flag       = st.rx_edge_flag;
    assign tx_break_line      = st.tx_brk;

    // checking helpers
    logic [8:0] brk_ticks;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            brk_ticks <= 9'h000;
        else if (tx_break_req && !st.tx_brk)
            brk_ticks <= 9'h000;
        else if (st.tx_brk && sample_tick)
            brk_ticks <= brk_ticks + 9'h001;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_arm_fe;
        rd_s1 && framing_error_flag;
    endsequence
    sequence s_clean_dat;
        rd_dat && !char_done && !rd_s1;
    endsequence

    chk_fe_with_full: assert property ($rose(framing_error_flag) |-> rx_full_flag)
        else $error("framing error rose without receive-full");
    // data read may trail the status read by a few cycles, reads take a cycle each
    chk_fe_clear_seq: assert property (s_arm_fe ##[1:4] s_clean_dat
        |=> !framing_error_flag)
        else $error("framing error not cleared by read sequence");
    chk_fe_no_clear: assert property (framing_error_flag && !rd_dat
        |=> framing_error_flag)
        else $error("framing error cleared without data read");
    chk_break_detect_enable_blocks: assert property ($rose(rx_full_flag)
        |-> !$past(st.break_detect_enable))
        else $error("receive-full set while break detect enabled");
    chk_brk_w1c: assert property (wr_s2 && reg_wdata[S2_BRK] && !break_pulse
        |=> !break_seen_flag)
        else $error("break flag not cleared by write one");
    chk_brk_w0_keep: assert property (wr_s2 && !reg_wdata[S2_BRK] && break_seen_flag
        |=> break_seen_flag)
        else $error("break flag lost on write zero");
    chk_edge_sets: assert property (st.line_prev && !line |=> rx_edge_flag)
        else $error("active edge did not set edge flag");
    chk_idle_standby: assert property (rx_standby && !st.standby_idle_wake_sel
        && !idle_flag && !wr_s2 |=> !idle_flag)
        else $error("idle flag set in standby with wake select low");
    chk_break_length: assert property ($fell(tx_break_line)
        |-> brk_ticks == {$past(brk_len), 4'h0})
        else $error("transmitted break length wrong");
    chk_bit5_zero: assert property (rd_s2 |=> reg_rdata[5] == 1'b0)
        else $error("status two bit 5 not zero");
endmodule
`default_nettype wire
